//--- common/ast_pkg.sv
// Package of constants, register map and carriers for the serial transceiver
package ast_pkg;
    // Register offsets
    localparam logic [3:0] AST_MODE_OFF   = 4'h0;
    localparam logic [3:0] AST_TXBUF_OFF  = 4'h1;
    localparam logic [3:0] AST_TXSTAT_OFF = 4'h2;
    localparam logic [3:0] AST_RXBUF_OFF  = 4'h3;
    localparam logic [3:0] AST_RXERR_OFF  = 4'h4;
    localparam logic [3:0] AST_BAUD_OFF   = 4'h5;
    localparam logic [3:0] AST_IRQ_OFF    = 4'h6;
    localparam logic [3:0] AST_MASK_OFF   = 4'h7;
    // Mode register bit positions
    localparam int AST_POWER_BIT = 7;
    localparam int AST_TXE_BIT   = 6;
    localparam int AST_RXE_BIT   = 5;
    localparam int AST_PSH_BIT   = 4;
    localparam int AST_PSL_BIT   = 3;
    localparam int AST_CL_BIT    = 2;
    localparam int AST_SL_BIT    = 1;
    localparam int AST_ISRM_BIT  = 0;
    // Transmit status bit positions
    localparam int AST_TXBF_BIT  = 1;
    localparam int AST_TXSF_BIT  = 0;
    // Receive error bit positions
    localparam int AST_PE_BIT    = 2;
    localparam int AST_FE_BIT    = 1;
    localparam int AST_OVE_BIT   = 0;
    // Interrupt bit positions
    localparam int AST_IRQ_TX    = 0;
    localparam int AST_IRQ_RX    = 1;
    localparam int AST_IRQ_ERR   = 2;
    // Reset values
    localparam logic [7:0]  AST_MODE_RST  = 8'h01;
    localparam logic [15:0] AST_BAUD_RST  = 16'h0043;
    localparam logic [2:0]  AST_MASK_RST  = 3'h0;
    // Extra operating clocks added to a back-to-back start bit
    localparam logic [1:0]  AST_START_STRETCH = 2'h2;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } ast_bus_s;

    typedef struct packed {
        logic       power;
        logic       txe;
        logic       rxe;
        logic [1:0] parity;
        logic       len8;
        logic       stop2;
        logic [15:0] baud;
    } ast_cfg_s;

    function automatic logic ast_parity(input logic [7:0] d, input logic len8,
                                        input logic [1:0] ps);
        logic p;
        p = len8 ? ^d : ^d[6:0];
        return (ps == 2'h3) ? ~p : p;
    endfunction : ast_parity
endpackage : ast_pkg

//--- verilog/ast_tx.sv
// Transmit shifter with start, data, parity and one or two stop bits
`timescale 1ns/1ps
module ast_tx
    import ast_pkg::*;
(
    // Clock and reset
    input  wire logic       mclk_in,
    input  wire logic       reset_n_in,
    // Control
    input  wire ast_cfg_s   cfg_in,
    input  wire logic       load_in,
    input  wire logic [7:0] data_in,
    input  wire logic       stretch_in,
    // Status and line
    output logic            busy_out,
    output logic            done_out,
    output logic            line_out
);
    typedef enum logic [2:0] {
        TX_IDLE = 3'b001, TX_SHIFT = 3'b010, TX_STOP = 3'b100
    } ast_tx_e;
    typedef struct packed {
        ast_tx_e     st;
        logic [15:0] cnt;
        logic [10:0] sh;
        logic [3:0]  bits;
        logic        stops;
        logic        line;
        logic        done;
    } ast_tx_s;
    ast_tx_s s_reg, s_next;

    always_comb begin
        s_next = s_reg;
        s_next.done = 1'b0;
        unique case (s_reg.st)
            TX_IDLE: begin
                if (load_in) begin
                    s_next.st = TX_SHIFT;
                    // Parity sits right after the last data bit in both lengths
                    s_next.sh = cfg_in.len8
                        ? {1'b1, ast_parity(data_in, cfg_in.len8, cfg_in.parity),
                           data_in, 1'b0}
                        : {2'b11, ast_parity(data_in, cfg_in.len8, cfg_in.parity),
                           data_in[6:0], 1'b0};
                    if (cfg_in.parity == 2'h0)
                        s_next.sh = {2'b11, data_in, 1'b0};
                    s_next.bits = 4'(7 + 32'(cfg_in.len8) + 32'(cfg_in.parity != 2'h0));
                    s_next.cnt = cfg_in.baud + (stretch_in ? 16'(AST_START_STRETCH)
                                                           : 16'h0000);
                    s_next.line = 1'b0;
                end
            end
            TX_SHIFT: begin
                if (s_reg.cnt != 16'h0000) begin
                    s_next.cnt = s_reg.cnt - 16'h0001;
                end else begin
                    s_next.cnt = cfg_in.baud;
                    s_next.sh = {1'b1, s_reg.sh[10:1]};
                    s_next.line = s_reg.sh[1];
                    if (s_reg.bits == 4'h0) begin
                        s_next.st = TX_STOP;
                        s_next.line = 1'b1;
                        s_next.stops = cfg_in.stop2;
                    end else begin
                        s_next.bits = s_reg.bits - 4'h1;
                    end
                end
            end
            TX_STOP: begin
                if (s_reg.cnt != 16'h0000) begin
                    s_next.cnt = s_reg.cnt - 16'h0001;
                end else if (s_reg.stops) begin
                    s_next.stops = 1'b0;
                    s_next.cnt = cfg_in.baud;
                end else begin
                    s_next.st = TX_IDLE;
                    s_next.done = 1'b1;
                end
            end
            default: s_next.st = TX_IDLE;
        endcase
        if (!cfg_in.power) begin
            s_next.st = TX_IDLE;
            s_next.line = 1'b1;
        end
    end

    // Only edges change the line, so a stopped clock keeps its level
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            s_reg <= '{st: TX_IDLE, cnt: 16'h0000, sh: 11'h7FF, bits: 4'h0,
                       stops: 1'b0, line: 1'b1, done: 1'b0};
        end else begin
            s_reg <= s_next;
        end
    end

    assign busy_out = (s_reg.st != TX_IDLE);
    assign done_out = s_reg.done;
    assign line_out = s_reg.line;
endmodule : ast_tx

//--- verilog/ast_rx.sv
// Receive sampler: start detect, mid-bit sampling, single stop check
`timescale 1ns/1ps
module ast_rx
    import ast_pkg::*;
(
    // Clock and reset
    input  wire logic       mclk_in,
    input  wire logic       reset_n_in,
    // Control and line
    input  wire ast_cfg_s   cfg_in,
    input  wire logic       line_in,
    // Received character
    output logic            valid_out,
    output logic [7:0]      data_out,
    output logic            perr_out,
    output logic            ferr_out
);
    typedef enum logic [2:0] {
        RX_IDLE = 3'b001, RX_DATA = 3'b010, RX_STOP = 3'b100
    } ast_rx_e;
    typedef struct packed {
        ast_rx_e     st;
        logic [15:0] cnt;
        logic [8:0]  sh;
        logic [3:0]  bits;
        logic        valid;
        logic        perr;
        logic        ferr;
    } ast_rx_s;
    ast_rx_s s_reg, s_next;
    logic [3:0] nbits;
    logic [7:0] dat;

    always_comb begin
        nbits = 4'(7 + 32'(cfg_in.len8) + 32'(cfg_in.parity != 2'h0));
        dat = cfg_in.len8 ? s_reg.sh[7:0] : {1'b0, s_reg.sh[6:0]};
        s_next = s_reg;
        s_next.valid = 1'b0;
        unique case (s_reg.st)
            RX_IDLE: begin
                // A low line at enable time is taken as a start bit
                if (cfg_in.power && cfg_in.rxe && !line_in) begin
                    s_next.st = RX_DATA;
                    s_next.cnt = cfg_in.baud + (cfg_in.baud >> 1);
                    s_next.bits = 4'h0;
                    s_next.sh = 9'h000;
                end
            end
            RX_DATA: begin
                if (s_reg.cnt != 16'h0000) begin
                    s_next.cnt = s_reg.cnt - 16'h0001;
                end else begin
                    s_next.cnt = cfg_in.baud;
                    s_next.sh[s_reg.bits] = line_in;
                    s_next.bits = s_reg.bits + 4'h1;
                    if (s_reg.bits == nbits - 4'h1)
                        s_next.st = RX_STOP;
                end
            end
            RX_STOP: begin
                // One stop bit only, stop length setting ignored
                if (s_reg.cnt != 16'h0000) begin
                    s_next.cnt = s_reg.cnt - 16'h0001;
                end else begin
                    s_next.st = RX_IDLE;
                    s_next.valid = 1'b1;
                    s_next.ferr = !line_in;
                    s_next.perr = (cfg_in.parity != 2'h0) &&
                        (s_reg.sh[cfg_in.len8 ? 8 : 7] !=
                         ast_parity(dat, cfg_in.len8, cfg_in.parity));
                end
            end
            default: s_next.st = RX_IDLE;
        endcase
        if (!cfg_in.power || !cfg_in.rxe)
            s_next.st = RX_IDLE;
    end

    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            s_reg <= '{st: RX_IDLE, cnt: 16'h0000, sh: 9'h000, bits: 4'h0,
                       valid: 1'b0, perr: 1'b0, ferr: 1'b0};
        end else begin
            s_reg <= s_next;
        end
    end

    assign valid_out = s_reg.valid;
    assign data_out  = cfg_in.len8 ? s_reg.sh[7:0] : {1'b0, s_reg.sh[6:0]};
    assign perr_out  = s_reg.perr;
    assign ferr_out  = s_reg.ferr;
endmodule : ast_rx

//--- verilog/ast_top.sv
// Register file, transmit double buffer, receive buffer and interrupt logic
`timescale 1ns/1ps
module ast_top
    import ast_pkg::*;
(
    // Clock and reset
    input  wire logic       mclk_in,
    input  wire logic       reset_n_in,
    // Register port
    input  wire logic [3:0] addr_in,
    input  wire logic [7:0] wdata_in,
    input  wire logic       wr_in,
    input  wire logic       rd_in,
    output logic [7:0]      rdata_out,
    // Serial lines
    input  wire logic       receive_line_in,
    output logic            transmit_line_out,
    // Interrupt
    output logic            irq_out
);
    typedef struct packed {
        logic [7:0]  mode;
        logic [15:0] baud;
        logic [7:0]  transmit_buffer;
        logic        transmit_buffer_full;
        logic        pend;
        logic        was_busy;
        logic [7:0]  receive_buffer;
        logic        rx_unread;
        logic [2:0]  receive_error_status;
        logic [2:0]  irq_stat;
        logic [2:0]  irq_mask;
        logic [7:0]  rdata;
        logic        irq;
        logic        tx_line;
    } ast_top_s;
    ast_top_s s_reg, s_next;

    ast_bus_s   bus;
    ast_cfg_s   cfg;
    logic       tx_busy, tx_done, tx_line, tx_load;
    logic       rx_valid, rx_perr, rx_ferr;
    logic [7:0] rx_data;
    logic [2:0] ev;
    logic [2:0] err_ev;

    assign bus = '{addr: addr_in, wdata: wdata_in, wr: wr_in, rd: rd_in};
    assign cfg = '{power: s_reg.mode[AST_POWER_BIT], txe: s_reg.mode[AST_TXE_BIT],
                   rxe: s_reg.mode[AST_RXE_BIT],
                   parity: {s_reg.mode[AST_PSH_BIT], s_reg.mode[AST_PSL_BIT]},
                   len8: s_reg.mode[AST_CL_BIT], stop2: s_reg.mode[AST_SL_BIT],
                   baud: s_reg.baud};

    // Next byte loads only when the shifter is idle; back-to-back loads stretch
    assign tx_load = s_reg.pend && !tx_busy && cfg.power && cfg.txe;

    ast_tx u_tx (
        .mclk_in    (mclk_in),
        .reset_n_in (reset_n_in),
        .cfg_in     (cfg),
        .load_in    (tx_load),
        .data_in    (s_reg.transmit_buffer),
        .stretch_in (tx_done || s_reg.was_busy),
        .busy_out   (tx_busy),
        .done_out   (tx_done),
        .line_out   (tx_line)
    );

    ast_rx u_rx (
        .mclk_in    (mclk_in),
        .reset_n_in (reset_n_in),
        .cfg_in     (cfg),
        .line_in    (receive_line_in),
        .valid_out  (rx_valid),
        .data_out   (rx_data),
        .perr_out   (rx_perr),
        .ferr_out   (rx_ferr)
    );

    always_comb begin
        s_next = s_reg;
        s_next.rdata = 8'h00;
        s_next.tx_line = tx_line;
        ev = 3'h0;
        err_ev = 3'h0;
        if (tx_load) begin
            s_next.pend = 1'b0;
            s_next.transmit_buffer_full = 1'b0;
        end
        // Stretch only a start bit that follows a just-finished frame
        s_next.was_busy = tx_done || (s_reg.was_busy && !tx_load && s_reg.pend);
        if (tx_done && !s_reg.pend)
            s_next.was_busy = 1'b0;
        if (tx_done)
            ev[AST_IRQ_TX] = 1'b1;
        if (bus.rd) begin
            unique case (bus.addr)
                AST_MODE_OFF:   s_next.rdata = s_reg.mode;
                AST_TXBUF_OFF:  s_next.rdata = s_reg.transmit_buffer;
                AST_TXSTAT_OFF: s_next.rdata = {6'h00, s_reg.transmit_buffer_full, tx_busy};
                AST_RXBUF_OFF: begin
                    s_next.rdata = s_reg.receive_buffer;
                    s_next.rx_unread = 1'b0;
                end
                AST_RXERR_OFF: begin
                    s_next.rdata = {5'h00, s_reg.receive_error_status};
                    s_next.receive_error_status = 3'h0;
                end
                AST_BAUD_OFF:   s_next.rdata = s_reg.baud[7:0];
                AST_IRQ_OFF:    s_next.rdata = {5'h00, s_reg.irq_stat};
                AST_MASK_OFF:   s_next.rdata = {5'h00, s_reg.irq_mask};
                default:        s_next.rdata = 8'h00;
            endcase
        end
        if (bus.wr) begin
            unique case (bus.addr)
                AST_MODE_OFF:   s_next.mode = bus.wdata;
                AST_TXBUF_OFF: begin
                    // Software must not write while full; such a write is ignored
                    if (!s_reg.transmit_buffer_full && cfg.power) begin
                        s_next.transmit_buffer = bus.wdata;
                        s_next.transmit_buffer_full = 1'b1;
                        s_next.pend = 1'b1;
                    end
                end
                AST_BAUD_OFF:   s_next.baud = {8'h00, bus.wdata};
                AST_IRQ_OFF:    s_next.irq_stat = s_reg.irq_stat & ~bus.wdata[2:0];
                AST_MASK_OFF:   s_next.irq_mask = bus.wdata[2:0];
                default: ;
            endcase
        end
        // After the bus, so new errors win over a same-cycle read; a character landing as the held one is read is lost as overrun
        if (rx_valid) begin
            err_ev = {rx_perr, rx_ferr, s_reg.rx_unread};
            if (!s_reg.rx_unread) begin
                s_next.receive_buffer = rx_data;
                s_next.rx_unread = 1'b1;
            end // Overrun leaves the held character untouched
            // Error routing bit folds errors into the receive event
            if (err_ev != 3'h0 && !s_reg.mode[AST_ISRM_BIT])
                ev[AST_IRQ_ERR] = 1'b1;
            else
                ev[AST_IRQ_RX] = 1'b1;
        end
        // Hardware set wins over a same-cycle clear
        s_next.irq_stat = s_next.irq_stat | ev;
        s_next.receive_error_status = s_next.receive_error_status | err_ev;
        if (!cfg.power) begin
            s_next.transmit_buffer_full = 1'b0;
            s_next.pend = 1'b0;
            s_next.rx_unread = 1'b0;
            s_next.receive_error_status = 3'h0;
        end
        s_next.irq = |(s_next.irq_stat & s_next.irq_mask);
    end

    // Single clock domain: no edges means all state holds
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            s_reg <= '{mode: AST_MODE_RST, baud: AST_BAUD_RST, transmit_buffer: 8'h00,
                       transmit_buffer_full: 1'b0, pend: 1'b0, was_busy: 1'b0,
                       receive_buffer: 8'h00, rx_unread: 1'b0,
                       receive_error_status: 3'h0, irq_stat: 3'h0,
                       irq_mask: AST_MASK_RST, rdata: 8'h00, irq: 1'b0, tx_line: 1'b1};
        end else begin
            s_reg <= s_next;
        end
    end

    assign rdata_out         = s_reg.rdata;
    assign transmit_line_out = s_reg.tx_line;
    assign irq_out           = s_reg.irq;
endmodule : ast_top

//--- sim/ast_assertions.sv
// Port-level checker for the serial transceiver top
`timescale 1ns/1ps
module ast_assertions
    import ast_pkg::*;
(
    // Clock and reset
    input wire logic       mclk_in,
    input wire logic       reset_n_in,
    // Register port
    input wire logic [3:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic       wr_in,
    input wire logic       rd_in,
    input wire logic [7:0] rdata_out,
    // Lines and interrupt
    input wire logic       receive_line_in,
    input wire logic       transmit_line_out,
    input wire logic       irq_out
);
    logic [7:0] mode_reg;
    logic [7:0] baud_reg;
    logic [2:0] mask_reg;

    // Shadows of what software last wrote; the design may not alter these itself
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            mode_reg <= AST_MODE_RST;
            baud_reg <= AST_BAUD_RST[7:0];
            mask_reg <= AST_MASK_RST;
        end else if (wr_in) begin
            if (addr_in == AST_MODE_OFF) mode_reg <= wdata_in;
            if (addr_in == AST_BAUD_OFF) baud_reg <= wdata_in;
            if (addr_in == AST_MASK_OFF) mask_reg <= wdata_in[2:0];
        end
    end

    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (!reset_n_in);

    a_mode_hold: assert property (
        rd_in && addr_in == AST_MODE_OFF |=> rdata_out == $past(mode_reg)) else $error("mode readback");
    a_baud_hold: assert property (
        rd_in && addr_in == AST_BAUD_OFF |=> rdata_out == $past(baud_reg)) else $error("baud readback");
    a_mask_hold: assert property (
        rd_in && addr_in == AST_MASK_OFF |=> rdata_out == {5'h00, $past(mask_reg)})
        else $error("mask readback");
    a_rdata_quiet: assert property (!rd_in |=> rdata_out == 8'h00) else $error("rdata not zero");
    a_unmapped_zero: assert property (
        rd_in && addr_in > AST_MASK_OFF |=> rdata_out == 8'h00) else $error("unmapped read");
    a_reset_idle: assert property (
        $rose(reset_n_in) |-> transmit_line_out && !irq_out) else $error("not idle after reset");
    a_irq_needs_mask: assert property (irq_out |-> mask_reg != 3'h0)
        else $error("irq with mask clear");
    a_mask_drops_irq: assert property (
        wr_in && addr_in == AST_MASK_OFF && wdata_in[2:0] == 3'h0 |-> ##3 !irq_out)
        else $error("irq stays after mask clear");

    c_irq_cycle: cover property (irq_out ##1 !irq_out);
    c_tx_start: cover property ($fell(transmit_line_out));
    c_rx_start: cover property ($fell(receive_line_in));
endmodule : ast_assertions

bind ast_top ast_assertions i_chk (.mclk_in(mclk_in), .reset_n_in(reset_n_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .receive_line_in(receive_line_in),
    .transmit_line_out(transmit_line_out), .irq_out(irq_out));

//--- sim/ast_remote_node.sv
// Far-side serial node: sends frames and decodes the transmit line
`timescale 1ns/1ps
module ast_remote_node #(
    parameter int BIT_CLKS = 16
) (
    // Clock and lines
    input  wire logic mclk_in,
    input  wire logic tx_line_in,
    output logic      rx_line_out
);
    logic [7:0] got_q[$];
    int         start_q[$];

    initial rx_line_out = 1'b1;

    // Plain node, never LIN, so back-to-back frames and parity are free
    // Eight data bits LSB first, no parity, one stop bit; a bad stop is sent on request
    task automatic send(input logic [7:0] d, input logic stop_ok);
        logic [9:0] f;
        f = {stop_ok, d, 1'b0};
        for (int i = 0; i < 10; i++) begin
            rx_line_out <= f[i];
            repeat (BIT_CLKS) @(posedge mclk_in);
        end
        // Back to idle a clock later, so a following send never drives the same step
        if (!stop_ok) begin
            rx_line_out <= 1'b1;
            @(posedge mclk_in);
        end
    endtask : send

    // Start length is measured as the low run, so callers send bytes with bit 0 set
    always begin : decode
        logic [7:0] d;
        int         n;
        @(negedge tx_line_in);
        n = 0;
        while (!tx_line_in) begin
            @(posedge mclk_in);
            #1;
            n++;
        end
        repeat (BIT_CLKS / 2) @(posedge mclk_in);
        #1;
        for (int i = 0; i < 8; i++) begin
            d[i] = tx_line_in;
            repeat (BIT_CLKS) @(posedge mclk_in);
            #1;
        end
        start_q.push_back(n);
        got_q.push_back(d);
    end
endmodule : ast_remote_node

//--- sim/ast_top_bench.sv
// Self-checking bench for the serial transceiver top
`timescale 1ns/1ps
module ast_top_bench
    import ast_pkg::*;
;
    localparam int BIT_CLKS = 16;
    logic       mclk_in;
    logic       reset_n_in = 1'b0;
    logic [3:0] addr_in    = 4'h0;
    logic [7:0] wdata_in   = 8'h00;
    logic       wr_in      = 1'b0;
    logic       rd_in      = 1'b0;
    logic [7:0] rdata_out;
    logic       rx_line;
    logic       tx_line;
    logic       irq_out;
    logic       clk_run    = 1'b1;
    int         miscompares = 0;
    int         compares    = 0;

    ast_top i_dut (.mclk_in(mclk_in), .reset_n_in(reset_n_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .receive_line_in(rx_line), .transmit_line_out(tx_line), .irq_out(irq_out));
    ast_remote_node #(.BIT_CLKS(BIT_CLKS)) i_node (.mclk_in(mclk_in),
        .tx_line_in(tx_line), .rx_line_out(rx_line));

    initial begin
        mclk_in = 1'b0;
        forever #4 mclk_in = clk_run ? ~mclk_in : mclk_in;
    end

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic bus_wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk_in);
        addr_in  <= a;
        wdata_in <= d;
        wr_in    <= 1'b1;
        @(posedge mclk_in);
        wr_in <= 1'b0;
    endtask : bus_wr

    task automatic bus_rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge mclk_in);
        addr_in <= a;
        rd_in   <= 1'b1;
        @(posedge mclk_in);
        rd_in <= 1'b0;
        #1;
        d = rdata_out;
    endtask : bus_rd

    task automatic rd_chk(input string what, input logic [3:0] a, input logic [7:0] exp);
        logic [7:0] d;
        bus_rd(a, d);
        chk(what, exp, d);
    endtask : rd_chk

    task automatic irq_chk(input logic exp);
        repeat (3) @(posedge mclk_in);
        #1;
        chk("irq line", {7'h00, exp}, {7'h00, irq_out});
    endtask : irq_chk

    task automatic do_reset();
        reset_n_in <= 1'b0;
        repeat (16) @(posedge mclk_in);
        reset_n_in <= 1'b1;
    endtask : do_reset

    task automatic t_reset_values();
        chk("idle line", 8'h01, {7'h00, tx_line});
        rd_chk("mode", AST_MODE_OFF, AST_MODE_RST);
        rd_chk("baud", AST_BAUD_OFF, AST_BAUD_RST[7:0]);
        rd_chk("mask", AST_MASK_OFF, {5'h00, AST_MASK_RST});
        bus_wr(4'hE, 8'hFF);
        rd_chk("unmapped", 4'hF, 8'h00);
    endtask : t_reset_values

    task automatic t_receive();
        bus_wr(AST_BAUD_OFF, 8'(BIT_CLKS - 1));
        bus_wr(AST_MASK_OFF, 8'h07);
        bus_wr(AST_MODE_OFF, 8'h86);
        bus_wr(AST_MODE_OFF, 8'hA6);
        // Two stop bits configured, but the node sends one, back to back
        i_node.send(8'hA5, 1'b1);
        i_node.send(8'h3C, 1'b1);
        repeat (BIT_CLKS) @(posedge mclk_in);
        irq_chk(1'b1);
        rd_chk("irq status", AST_IRQ_OFF, 8'h06);
        rd_chk("rx errors", AST_RXERR_OFF, 8'h01);
        rd_chk("rx buffer", AST_RXBUF_OFF, 8'hA5);
        bus_wr(AST_MASK_OFF, 8'h00);
        irq_chk(1'b0);
        bus_wr(AST_MASK_OFF, 8'h07);
        irq_chk(1'b1);
        bus_wr(AST_IRQ_OFF, 8'h07);
        irq_chk(1'b0);
    endtask : t_receive

    task automatic t_rx_late();
        bus_wr(AST_MODE_OFF, 8'h86);
        bus_wr(AST_MODE_OFF, 8'h06);
        bus_wr(AST_MODE_OFF, 8'h86);
        // Line already low when reception is enabled
        fork
            i_node.send(8'hC3, 1'b1);
            bus_wr(AST_MODE_OFF, 8'hA6);
        join
        repeat (BIT_CLKS) @(posedge mclk_in);
        rd_chk("late rx buffer", AST_RXBUF_OFF, 8'hC3);
    endtask : t_rx_late

    task automatic t_frame_error();
        logic [7:0] d;
        i_node.send(8'hFF, 1'b0);
        bus_rd(AST_RXERR_OFF, d);
        chk("framing flag", 8'h02, d & 8'h02);
    endtask : t_frame_error

    task automatic t_transmit();
        logic [7:0] s;
        bus_wr(AST_MODE_OFF, 8'h86);
        bus_wr(AST_MODE_OFF, 8'h84);
        bus_wr(AST_IRQ_OFF, 8'h07);
        i_node.got_q.delete();
        i_node.start_q.delete();
        bus_wr(AST_MODE_OFF, 8'hC4);
        bus_wr(AST_TXBUF_OFF, 8'h55);
        for (int i = 0; i < 100; i++) begin
            bus_rd(AST_TXSTAT_OFF, s);
            if (!s[AST_TXBF_BIT]) break;
        end
        bus_wr(AST_TXBUF_OFF, 8'h0F);
        rd_chk("tx status", AST_TXSTAT_OFF, 8'h03);
        for (int i = 0; i < 1000 && i_node.got_q.size() < 2; i++) @(posedge mclk_in);
        repeat (2 * BIT_CLKS) @(posedge mclk_in);
        chk("frames", 8'h02, 8'(i_node.got_q.size()));
        chk("byte 0", 8'h55, i_node.got_q[0]);
        chk("byte 1", 8'h0F, i_node.got_q[1]);
        chk("start 0", 8'(BIT_CLKS), 8'(i_node.start_q[0]));
        chk("start 1", 8'(BIT_CLKS) + 8'(AST_START_STRETCH), 8'(i_node.start_q[1]));
        rd_chk("tx done", AST_IRQ_OFF, 8'h01);
    endtask : t_transmit

    task automatic t_clock_stop();
        logic held;
        bus_wr(AST_TXBUF_OFF, 8'h33);
        repeat (40) @(posedge mclk_in);
        #1;
        held = tx_line;
        clk_run = 1'b0;
        #400;
        chk("held line", {7'h00, held}, {7'h00, tx_line});
        clk_run = 1'b1;
        rd_chk("baud kept", AST_BAUD_OFF, 8'(BIT_CLKS - 1));
        rd_chk("mode kept", AST_MODE_OFF, 8'hC4);
        do_reset();
        rd_chk("mode after reset", AST_MODE_OFF, AST_MODE_RST);
    endtask : t_clock_stop

    task automatic tally_and_finish();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    // Whole run is some twelve hundred cycles; this cuts a hang well beyond that
    initial begin
        #80000;
        miscompares++;
        tally_and_finish();
    end

    initial begin
        do_reset();
        t_reset_values();
        t_receive();
        t_rx_late();
        t_frame_error();
        t_transmit();
        t_clock_stop();
        tally_and_finish();
    end
endmodule : ast_top_bench
